// [rtl/sideband_error_pins.sv]
// Sideband error pin sequencer: catastrophic, recoverable and I/O outputs
`include "sideband_error_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module sideband_error_pins
  import sideband_error_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clk_en,
  // Core and uncore error sources, one-cycle requests
  input  wire logic       nonrecoverable_fault,
  input  wire logic       fatal_fault,
  input  wire logic       internal_fault,
  input  wire logic       recoverable_uncorrected_fault,
  input  wire logic       local_check_exception,
  input  wire logic       uncorrected_no_action_event,
  // I/O unit error sources, levels
  input  wire logic       io_corrected_fault,
  input  wire logic       integrated_memory_ctrl_corrected,
  input  wire logic       persistent_memory_alert,
  input  wire logic       mgmt_bus_hang,
  input  wire logic       io_uncorrected_fault,
  input  wire logic       io_fatal_fault,
  // Active-low sideband pins
  output logic            catastrophic_error_out_n,
  output logic            recoverable_check_out_n,
  output logic [2:0]      io_error_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Catastrophic output sequencer

  cat_state_t             cat_state_reg;
  cat_state_t             cat_state_next;
  logic [4:0]             cat_count_reg;
  logic [4:0]             cat_count_next;
  logic                   cat_out_reg;
  logic                   cat_out_next;
  logic                   cat_pulse_req;
  logic                   cat_hold_req;

  // Fatal faults share the pulse with non-recoverable ones
  assign cat_pulse_req = nonrecoverable_fault | fatal_fault;
  assign cat_hold_req  = internal_fault;

  always_comb begin
    cat_state_next = cat_state_reg;
    cat_count_next = cat_count_reg;
    case (cat_state_reg)
      CAT_IDLE: begin
        if (cat_hold_req) begin
          cat_state_next = CAT_HOLD;
        end else if (cat_pulse_req) begin
          cat_state_next = CAT_PULSE;
          cat_count_next = 5'h00;
        end
      end
      CAT_PULSE: begin
        if (cat_hold_req) begin
          cat_state_next = CAT_HOLD;
        end else if (cat_count_reg == `PULSE_LAST) begin
          cat_state_next = CAT_IDLE;
        end else begin
          cat_count_next = cat_count_reg + 5'h01;
        end
      end
      CAT_HOLD: begin
        cat_state_next = CAT_HOLD;
      end
      default: begin
        cat_state_next = CAT_IDLE;
      end
    endcase
    cat_out_next = (cat_state_next == CAT_IDLE);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cat_state_reg <= CAT_IDLE;
      cat_count_reg <= 5'h00;
      cat_out_reg   <= `OUT_IDLE;
    end else if (clk_en) begin
      cat_state_reg <= cat_state_next;
      cat_count_reg <= cat_count_next;
      cat_out_reg   <= cat_out_next;
    end
  end

  assign catastrophic_error_out_n = cat_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Recoverable machine-check pulse

  logic                   rec_busy_reg;
  logic                   rec_busy_next;
  logic [4:0]             rec_count_reg;
  logic [4:0]             rec_count_next;
  logic                   rec_out_reg;
  logic                   rec_out_next;
  logic                   rec_req;

  // Local and no-action events are not inputs to the pulse; any error that
  // also escalates to the catastrophic output is reported there only
  assign rec_req = recoverable_uncorrected_fault
                   & ~cat_pulse_req & ~cat_hold_req;

  always_comb begin
    rec_busy_next  = rec_busy_reg;
    rec_count_next = rec_count_reg;
    if (!rec_busy_reg) begin
      if (rec_req) begin
        rec_busy_next  = 1'b1;
        rec_count_next = 5'h00;
      end
    end else if (rec_count_reg == `PULSE_LAST) begin
      rec_busy_next = 1'b0;
    end else begin
      rec_count_next = rec_count_reg + 5'h01;
    end
    rec_out_next = ~rec_busy_next;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rec_busy_reg  <= 1'b0;
      rec_count_reg <= 5'h00;
      rec_out_reg   <= `OUT_IDLE;
    end else if (clk_en) begin
      rec_busy_reg  <= rec_busy_next;
      rec_count_reg <= rec_count_next;
      rec_out_reg   <= rec_out_next;
    end
  end

  assign recoverable_check_out_n = rec_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // I/O error vector, registered active-low levels

  logic [2:0]             io_reg;
  logic [2:0]             io_next;

  always_comb begin
    io_next = `IOERR_IDLE;
    io_next[`IOERR_CORRECTED] = ~(io_corrected_fault
                                  | integrated_memory_ctrl_corrected
                                  | persistent_memory_alert
                                  | mgmt_bus_hang);
    io_next[`IOERR_UNCORRECTED] = ~io_uncorrected_fault;
    io_next[`IOERR_FATAL] = ~io_fatal_fault;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      io_reg <= `IOERR_IDLE;
    end else if (clk_en) begin
      io_reg <= io_next;
    end
  end

  assign io_error_out_n = io_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Run counters: enabled cycles the catastrophic and recoverable outputs have stayed low so far.
  // They saturate well above one pulse, so a held level never wraps.
  logic [5:0]             chk_cat_run_reg;
  logic [5:0]             chk_cat_run_next;
  logic [5:0]             chk_rec_run_reg;
  logic [5:0]             chk_rec_run_next;

  always_comb begin
    chk_cat_run_next = chk_cat_run_reg;
    chk_rec_run_next = chk_rec_run_reg;
    if (catastrophic_error_out_n) begin
      chk_cat_run_next = 6'h00;
    end else if (chk_cat_run_reg != 6'h3F) begin
      chk_cat_run_next = chk_cat_run_reg + 6'h01;
    end
    if (recoverable_check_out_n) begin
      chk_rec_run_next = 6'h00;
    end else if (chk_rec_run_reg != 6'h3F) begin
      chk_rec_run_next = chk_rec_run_reg + 6'h01;
    end
  end

  // Frozen with the rest of the block while the enable is low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chk_cat_run_reg <= 6'h00;
      chk_rec_run_reg <= 6'h00;
    end else if (clk_en) begin
      chk_cat_run_reg <= chk_cat_run_next;
      chk_rec_run_reg <= chk_rec_run_next;
    end
  end

  // Pulse request accepted from idle
  sequence s_cat_request;
    cat_state_reg == CAT_IDLE && clk_en && cat_pulse_req && !cat_hold_req;
  endsequence

  // End of a catastrophic pulse
  sequence s_cat_released;
    $rose(catastrophic_error_out_n);
  endsequence

  // Recoverable request accepted from idle
  sequence s_rec_request;
    clk_en && rec_req && !rec_busy_reg;
  endsequence

  // End of a recoverable pulse
  sequence s_rec_released;
    $rose(recoverable_check_out_n);
  endsequence

  a_cat_pulse_len: assert property (
    @(posedge clock) disable iff (!rstn)
    (cat_state_reg == CAT_PULSE) |-> chk_cat_run_reg <= 6'd15)
    else $error("catastrophic pulse longer than 16 cycles");

  a_cat_pulse_shape: assert property (
    @(posedge clock) disable iff (!rstn)
    s_cat_request |=> !catastrophic_error_out_n)
    else $error("catastrophic pulse did not start");

  a_cat_exact: assert property (
    @(posedge clock) disable iff (!rstn)
    s_cat_released |-> chk_cat_run_reg == 6'd16)
    else $error("catastrophic pulse not 16 cycles long");

  a_cat_holds: assert property (
    @(posedge clock) disable iff (!rstn)
    (clk_en && internal_fault) |=> !catastrophic_error_out_n [*8])
    else $error("catastrophic level not held");

  a_cat_sticky: assert property (
    @(posedge clock) disable iff (!rstn)
    (cat_state_reg == CAT_HOLD) |=> !catastrophic_error_out_n)
    else $error("catastrophic hold released");

  a_rec_start: assert property (
    @(posedge clock) disable iff (!rstn)
    s_rec_request |=> !recoverable_check_out_n)
    else $error("recoverable pulse did not start");

  a_rec_length: assert property (
    @(posedge clock) disable iff (!rstn)
    s_rec_released |-> chk_rec_run_reg == 6'd16)
    else $error("recoverable pulse not 16 cycles long");

  a_rec_bounded: assert property (
    @(posedge clock) disable iff (!rstn)
    rec_busy_reg |-> chk_rec_run_reg <= 6'd15)
    else $error("recoverable pulse longer than 16 cycles");

  a_rec_ignored: assert property (
    @(posedge clock) disable iff (!rstn)
    (clk_en && !rec_busy_reg && !recoverable_uncorrected_fault
     && (local_check_exception || uncorrected_no_action_event))
    |=> recoverable_check_out_n)
    else $error("recoverable output moved on a local or no-action event");

  a_rec_quiet: assert property (
    @(posedge clock) disable iff (!rstn)
    (clk_en && !rec_busy_reg && !recoverable_uncorrected_fault)
    |=> recoverable_check_out_n)
    else $error("recoverable output moved without a recoverable fault");

  a_one_output: assert property (
    @(posedge clock) disable iff (!rstn)
    (clk_en && cat_pulse_req && !rec_busy_reg) |=> recoverable_check_out_n)
    else $error("both outputs asserted for one error");

  a_io_vector: assert property (
    @(posedge clock) disable iff (!rstn)
    clk_en |=> io_error_out_n == {~$past(io_fatal_fault),
                                  ~$past(io_uncorrected_fault),
                                  ~($past(io_corrected_fault)
                                    | $past(integrated_memory_ctrl_corrected)
                                    | $past(persistent_memory_alert)
                                    | $past(mgmt_bus_hang))})
    else $error("I/O error vector mismatch");

endmodule

`default_nettype wire

// [shared/sideband_error_defs.svh]
// Constants for the sideband error signalling block
`ifndef SIDEBAND_ERROR_DEFS_SVH
`define SIDEBAND_ERROR_DEFS_SVH

// Pulse length in base-clock cycles
`define PULSE_CYCLES       5'd16
`define PULSE_LAST         5'd15
// Positions in the I/O error vector
`define IOERR_CORRECTED    0
`define IOERR_UNCORRECTED  1
`define IOERR_FATAL        2
// Reset value of every active-low output
`define OUT_IDLE           1'b1
`define IOERR_IDLE         3'h7

`endif

// [shared/sideband_error_pkg.sv]
// Types for the sideband error signalling block
package sideband_error_pkg;

  // Catastrophic output sequencer, Gray coded along idle-pulse-hold
  typedef enum logic [1:0] {
    CAT_IDLE  = 2'b00,
    CAT_PULSE = 2'b01,
    CAT_HOLD  = 2'b11
  } cat_state_t;

endpackage

// [test/error_monitor.sv]
// Board-side monitor that classifies catastrophic pulses and holds
`timescale 1ns/1ns
`default_nettype none

module error_monitor (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Observed active-low line
  input  wire logic       line_n,
  // Classification
  output logic [7:0]      last_len,
  output logic            held
);
  logic [7:0] run_reg;

  // Count low cycles; a finished low run is a pulse of that length
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_reg  <= 8'h00;
      last_len <= 8'h00;
    end else if (line_n === 1'b0) begin
      if (run_reg != 8'hFF) run_reg <= run_reg + 8'h01;
    end else begin
      if (run_reg != 8'h00) last_len <= run_reg;
      run_reg <= 8'h00;
    end
  end

  // Low longer than one pulse means a permanent level
  assign held = (run_reg > 8'h10);
endmodule
`default_nettype wire

// [test/test_sideband_error_pins.sv]
// Testbench for the sideband error pin sequencer
`timescale 1ns/1ns
`default_nettype none

module test_sideband_error_pins;
  logic       clock = 1'b0;
  logic       rstn  = 1'b0;
  logic       clk_en = 1'b1;
  logic [5:0] req   = 6'h00;
  logic [5:0] iolv  = 6'h00;
  logic       cat;
  logic       rec;
  logic [2:0] io;
  logic [7:0] last_len;
  logic       held;
  int         mismatches = 0;
  int         total_checks = 0;

  sideband_error_pins i_sideband_error_pins (
    .clock(clock), .rstn(rstn), .clk_en(clk_en),
    .nonrecoverable_fault(req[0]), .fatal_fault(req[1]),
    .internal_fault(req[2]), .recoverable_uncorrected_fault(req[3]),
    .local_check_exception(req[4]), .uncorrected_no_action_event(req[5]),
    .io_corrected_fault(iolv[0]), .integrated_memory_ctrl_corrected(iolv[1]),
    .persistent_memory_alert(iolv[2]), .mgmt_bus_hang(iolv[3]),
    .io_uncorrected_fault(iolv[4]), .io_fatal_fault(iolv[5]),
    .catastrophic_error_out_n(cat), .recoverable_check_out_n(rec),
    .io_error_out_n(io));

  error_monitor i_error_monitor (.clock(clock), .rstn(rstn),
    .line_n(cat), .last_len(last_len), .held(held));

  initial begin
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle request, then count low cycles on both outputs
  task pulse(input logic [5:0] m, output logic [7:0] nc, output logic [7:0] nr);
    nc = 8'h00;
    nr = 8'h00;
    @(posedge clock) req <= m;
    @(posedge clock) req <= 6'h00;
    repeat (24) begin
      #1;
      if (cat === 1'b0) nc++;
      if (rec === 1'b0) nr++;
      @(posedge clock);
    end
  endtask

  task t_idle;
    chk("cat", 8'h01, {7'h0, cat});
    chk("rec", 8'h01, {7'h0, rec});
    chk("io", 8'h07, {5'h0, io});
  endtask

  task t_pulses;
    logic [5:0] m[6] = '{6'h01, 6'h02, 6'h08, 6'h10, 6'h20, 6'h09};
    logic [7:0] ec[6] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 8'h10};
    logic [7:0] er[6] = '{8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
    logic [7:0] nc, nr;
    for (int i = 0; i < 6; i++) begin
      pulse(m[i], nc, nr);
      chk("cat_low", ec[i], nc);
      chk("rec_low", er[i], nr);
    end
    chk("mon_len", 8'h10, last_len);
  endtask

  task t_io;
    logic [2:0] e[6] = '{3'h6, 3'h6, 3'h6, 3'h6, 3'h5, 3'h3};
    for (int i = 0; i < 6; i++) begin
      @(posedge clock) iolv <= 6'h01 << i;
      repeat (2) @(posedge clock);
      #1;
      chk("io", {5'h0, e[i]}, {5'h0, io});
    end
    @(posedge clock) iolv <= 6'h00;
  endtask

  // Enable low for 8 edges inside a pulse stretches it by 8 cycles
  task t_freeze;
    logic [7:0] nc;
    nc = 8'h00;
    @(posedge clock) req <= 6'h01;
    @(posedge clock) req <= 6'h00;
    for (int i = 0; i < 40; i++) begin
      #1;
      if (cat === 1'b0) nc++;
      @(posedge clock);
      clk_en <= (i < 3 || i > 10);
    end
    chk("freeze_low", 8'h18, nc);
  endtask

  task t_hold;
    logic [7:0] nc, nr;
    pulse(6'h04, nc, nr);
    chk("hold_low", 8'h18, nc);
    pulse(6'h01, nc, nr);
    chk("hold_low", 8'h18, nc);
    chk("mon_held", 8'h01, {7'h0, held});
    @(posedge clock) rstn <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    t_idle();
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    #1;
    t_idle();
    @(posedge clock) rstn <= 1'b1;
    @(posedge clock);
    #1;
    t_idle();
    t_pulses();
    t_io();
    t_freeze();
    t_hold();
    summarize();
  end
endmodule
`default_nettype wire
